// ### logic/ofw_addr_regs.sv
// Purpose: per-state irq write address registers and write launcher
// Assumes: page select and offset come from the owning component's decoder
// Notes:   accesses outside the two offsets read zero and are ignored
`timescale 1ns/1ps
module ofw_addr_regs
#(
	parameter bit VERSION_1P1_FEATURE        = 1'b1,
	parameter bit OVERFLOW_IRQ_WRITE_CAPABLE = 1'b1,
	parameter bit REALM_SECURITY_EXTENSION   = 1'b1
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// register access from the feature pages
	input  wire logic        regReq,
	input  wire logic        regWrite,
	input  wire logic [1:0]  regSpace,
	input  wire logic [11:0] regOffset,
	input  wire logic [31:0] regWdata,
	output logic             regAck,
	output logic [31:0]      regRdata,
	// overflow events and enables per state
	input  wire logic [3:0]  overflowEvent,
	input  wire logic [3:0]  overflowIrqWriteEnable,
	// irq write request to the message engine
	output logic             irqWriteValid,
	input  wire logic        irqWriteReady,
	output logic [51:0]      irqWriteAddr,
	output logic [1:0]       irqWriteSpace,
	// wired overflow interrupts per state
	output logic [3:0]       hardwiredIrq
);

	// ***************************************************************
	// declarations
	// ***************************************************************
	ofw_copy_if copyIf [ofw_pkg::NUM_SPACES] ();

	logic [29:0] lowOf  [ofw_pkg::NUM_SPACES];
	logic [19:0] highOf [ofw_pkg::NUM_SPACES];
	logic [3:0]  spaceOpen;
	logic [3:0]  selSpace;
	logic [3:0]  effEnable;
	logic        blockPresent;
	logic        hitLow;
	logic        hitHigh;
	logic        selAny;
	logic [29:0] lowOfSel;
	logic [19:0] highOfSel;
	logic [31:0] readValue;

	logic        regAck_reg;
	logic [31:0] regRdata_reg;
	logic [31:0] regRdata_next;

	ofw_pkg::ofw_eng_state_t engState_reg;
	ofw_pkg::ofw_eng_state_t engState_next;
	logic [3:0]  pending_reg;
	logic [3:0]  pending_next;
	logic [3:0]  issueMask;
	logic [1:0]  pickIdx;
	logic        anyPending;
	logic        launch;
	logic [51:0] launchAddr;
	logic        irqWriteValid_reg;
	logic [51:0] irqWriteAddr_reg;
	logic [1:0]  irqWriteSpace_reg;
	logic [3:0]  hardwiredIrq_reg;

	// ***************************************************************
	// presence and page decode
	// ***************************************************************
	// the bank exists only with both features; else read zero, ignore
	assign blockPresent = VERSION_1P1_FEATURE
		&& OVERFLOW_IRQ_WRITE_CAPABLE;
	assign hitLow  = (regOffset == ofw_pkg::OFF_ADDR_LOW);
	assign hitHigh = (regOffset == ofw_pkg::OFF_ADDR_HIGH);
	assign selAny  = |selSpace;

	// one copy per state, reached only from that state's page
	for (genvar s = 0; s < ofw_pkg::NUM_SPACES; s++)
	begin : g_space
		if (s < 2)
		begin : g_open
			assign spaceOpen[s] = 1'b1;
		end
		else
		begin : g_realm
			assign spaceOpen[s] = REALM_SECURITY_EXTENSION;
		end
		assign selSpace[s] = regReq && blockPresent && spaceOpen[s]
			&& (regSpace == 2'(s));
		assign copyIf[s].wrLow  = selSpace[s] && regWrite && hitLow;
		assign copyIf[s].wrHigh = selSpace[s] && regWrite && hitHigh;
		assign copyIf[s].wdata  = regWdata;
		assign lowOf[s]  = copyIf[s].lowField;
		assign highOf[s] = copyIf[s].highField;
		assign effEnable[s] = overflowIrqWriteEnable[s]
			&& blockPresent && spaceOpen[s];

		ofw_state_copy u_copy
		(
			.clk   (clk),
			.rst_b (rst_b),
			.port  (copyIf[s])
		);
	end

	// ***************************************************************
	// read path
	// ***************************************************************
	// low pair is forced to zero on every read
	assign lowOfSel  = lowOf[regSpace];
	assign highOfSel = highOf[regSpace];
	assign readValue = !selAny ? 32'h0000_0000
		: hitLow  ? {lowOfSel, ofw_pkg::LOW_FIXED_BITS}
		: hitHigh ? {ofw_pkg::HIGH_RESERVED, highOfSel}
		: 32'h0000_0000;
	assign regRdata_next = (regReq && !regWrite) ? readValue
		: 32'h0000_0000;

	// answer one cycle after every request, reads and writes alike
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			regAck_reg   <= 1'b0;
			regRdata_reg <= 32'h0000_0000;
		end
		else
		begin
			regAck_reg   <= regReq;
			regRdata_reg <= regRdata_next;
		end
	end

	// ***************************************************************
	// irq write launcher
	// ***************************************************************
	// lowest pending state first; fixed priority may starve realm
	always_comb
	begin
		pickIdx = 2'b00;
		for (int i = ofw_pkg::NUM_SPACES - 1; i >= 0; i--)
		begin
			if (pending_reg[i])
				pickIdx = 2'(i);
		end
	end

	assign anyPending = |pending_reg;
	assign launch     = (engState_reg == ofw_pkg::ENG_IDLE) && anyPending;
	assign issueMask  = launch ? (4'h1 << pickIdx) : 4'h0;
	assign launchAddr = {highOf[pickIdx], lowOf[pickIdx],
		ofw_pkg::LOW_FIXED_BITS};
	// a new event beats the clear of the same bit
	assign pending_next = (pending_reg & ~issueMask)
		| (overflowEvent & effEnable);

	always_comb
	begin
		case (engState_reg)
			ofw_pkg::ENG_IDLE:
				engState_next = launch ? ofw_pkg::ENG_SEND : ofw_pkg::ENG_IDLE;
			ofw_pkg::ENG_SEND:
				engState_next = irqWriteReady ? ofw_pkg::ENG_IDLE
					: ofw_pkg::ENG_SEND;
			default:
				engState_next = ofw_pkg::ENG_IDLE;
		endcase
	end

	// address is frozen at launch so a rewrite cannot tear it
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			engState_reg      <= ofw_pkg::ENG_IDLE;
			pending_reg       <= 4'h0;
			irqWriteValid_reg <= 1'b0;
			irqWriteAddr_reg  <= 52'h0_0000_0000_0000;
			irqWriteSpace_reg <= 2'b00;
		end
		else
		begin
			engState_reg      <= engState_next;
			pending_reg       <= pending_next;
			irqWriteValid_reg <= (engState_next == ofw_pkg::ENG_SEND);
			if (launch)
			begin
				irqWriteAddr_reg  <= launchAddr;
				irqWriteSpace_reg <= pickIdx;
			end
		end
	end

	// wired line only for states whose write path is off
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			hardwiredIrq_reg <= 4'h0;
		else
			hardwiredIrq_reg <= overflowEvent & ~effEnable;
	end

	assign regAck        = regAck_reg;
	assign regRdata      = regRdata_reg;
	assign irqWriteValid = irqWriteValid_reg;
	assign irqWriteAddr  = irqWriteAddr_reg;
	assign irqWriteSpace = irqWriteSpace_reg;
	assign hardwiredIrq  = hardwiredIrq_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	a_low_bits_zero: assert property (
		@(posedge clk) disable iff (!rst_b)
		(regReq && !regWrite && hitLow) |=> (regRdata[1:0] == 2'b00))
		else $error("low register bits 1:0 read nonzero");

	a_copies_separate: assert property (
		@(posedge clk) disable iff (!rst_b)
		(regReq && regWrite && regSpace == 2'b00) |=> $stable(lowOf[1]))
		else $error("secure write changed the non-secure copy");

	a_space_read_match: assert property (
		@(posedge clk) disable iff (!rst_b)
		(regReq && !regWrite && hitHigh && selAny)
		|=> (regRdata[19:0] == $past(highOfSel)) && regAck)
		else $error("read did not return its own state's copy");

	a_open_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		(blockPresent && regReq && regWrite && hitLow
			&& regSpace == 2'b01)
		|=> (lowOf[1] == $past(regWdata[31:2])))
		else $error("non-secure write was not stored");

	a_realm_closed: assert property (
		@(posedge clk) disable iff (!rst_b)
		(!REALM_SECURITY_EXTENSION && regReq && regSpace[1])
		|=> (regRdata == 32'h0000_0000))
		else $error("root or realm page answered without extension");

	a_absent_raz: assert property (
		@(posedge clk) disable iff (!rst_b)
		(!blockPresent && regAck) |-> (regRdata == 32'h0000_0000))
		else $error("absent bank returned data");

	a_wired_suppress: assert property (
		@(posedge clk) disable iff (!rst_b)
		(overflowEvent[0] && effEnable[0])
		|=> !hardwiredIrq[0] ##[0:8] irqWriteValid)
		else $error("enabled overflow raised wire or no write");

	a_write_addr_form: assert property (
		@(posedge clk) disable iff (!rst_b)
		launch |=> irqWriteValid && (irqWriteAddr == $past(launchAddr))
			&& (irqWriteAddr[1:0] == 2'b00))
		else $error("irq write address not formed from the fields");

	a_valid_holds: assert property (
		@(posedge clk) disable iff (!rst_b)
		(irqWriteValid && !irqWriteReady)
		|=> irqWriteValid && $stable(irqWriteAddr))
		else $error("irq write dropped before acceptance");

endmodule

// ### inc/ofw_pkg.sv
// Purpose: constants and types for the overflow irq write address bank
// Assumes: one clock, synchronous active-low reset
// Notes:   offsets are byte offsets inside each security state's page
// Notes on behaviour
// - high register bits 19:0 hold write address bits 51:32.
// - low register bits 31:2 hold write address bits 31:2, same positions.
// - low register bits 1:0 read zero and ignore writes.
// - separate copies for Secure, Non-secure, Root and Realm states.
// - each copy reachable only through its own state's page.
// - Secure and Non-secure copies are read-write at their offsets.
// - Root and Realm copies are read-write only with the realm extension.
// - without version 1.1 and write capability, registers read zero, ignore writes.
// - irq write support needs all five companion registers implemented together.
// - with write enable set, send the irq write and suppress the wired irq.
package ofw_pkg;

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [11:0] OFF_ADDR_LOW  = 12'h08e0;
	localparam logic [11:0] OFF_ADDR_HIGH = 12'h08e4;

	// ***************************************************************
	// field layout and reset values
	// ***************************************************************
	localparam int unsigned NUM_SPACES      = 4;
	localparam int unsigned LOW_FIELD_LSB   = 2;
	localparam int unsigned LOW_FIELD_MSB   = 31;
	localparam int unsigned LOW_FIELD_W     = 30;
	localparam int unsigned HIGH_FIELD_MSB  = 19;
	localparam int unsigned HIGH_FIELD_W    = 20;
	localparam int unsigned ADDR_W          = 52;
	localparam logic [1:0]  LOW_FIXED_BITS  = 2'h0;
	localparam logic [29:0] RESET_LOW_FIELD  = 30'h0000_0000;
	localparam logic [19:0] RESET_HIGH_FIELD = 20'h0_0000;
	localparam logic [11:0] HIGH_RESERVED    = 12'h000;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [1:0]
	{
		SPACE_SECURE    = 2'b00,
		SPACE_NONSECURE = 2'b01,
		SPACE_ROOT      = 2'b10,
		SPACE_REALM     = 2'b11
	} ofw_space_t;

	typedef enum logic [0:0]
	{
		ENG_IDLE = 1'b0,
		ENG_SEND = 1'b1
	} ofw_eng_state_t;

endpackage

// ### inc/ofw_copy_if.sv
// Purpose: carries one security state's register copy to the bank
// Assumes: driven and read on the bank clock
// Notes:   write strobes are one-cycle pulses
`timescale 1ns/1ps
interface ofw_copy_if;
	logic        wrLow;
	logic        wrHigh;
	logic [31:0] wdata;
	logic [29:0] lowField;
	logic [19:0] highField;

	modport copy
	(
		input  wrLow,
		input  wrHigh,
		input  wdata,
		output lowField,
		output highField
	);

	modport ctl
	(
		output wrLow,
		output wrHigh,
		output wdata,
		input  lowField,
		input  highField
	);
endinterface

// ### logic/ofw_state_copy.sv
// Purpose: one security state's low and high address fields
// Assumes: strobes already decoded for this state only
// Notes:   bits 1:0 of the low word are not stored at all
`timescale 1ns/1ps
module ofw_state_copy
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register side
	ofw_copy_if.copy port
);

	logic [29:0] lowField_reg;
	logic [19:0] highField_reg;

	// ***************************************************************
	// storage
	// ***************************************************************
	// only bits 31:2 are kept, so the low pair cannot be written
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			lowField_reg <= ofw_pkg::RESET_LOW_FIELD;
		else if (port.wrLow)
			lowField_reg <= port.wdata[31:2];
	end

	// bits 31:20 of a high write are dropped
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			highField_reg <= ofw_pkg::RESET_HIGH_FIELD;
		else if (port.wrHigh)
			highField_reg <= port.wdata[19:0];
	end

	assign port.lowField  = lowField_reg;
	assign port.highField = highField_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	a_low_field_load: assert property (
		@(posedge clk) disable iff (!rst_b)
		port.wrLow |=> (port.lowField == $past(port.wdata[31:2])))
		else $error("low field did not take written bits 31:2");

	a_high_field_load: assert property (
		@(posedge clk) disable iff (!rst_b)
		(port.wrHigh ##1 !port.wrHigh)
		|=> (port.highField == $past(port.wdata[19:0], 2)))
		else $error("high field lost written bits 19:0");

endmodule

// ### dv/ofw_tb.sv
// Purpose: self-checking bench for the overflow irq write address bank
// Assumes: inputs change on the falling edge, one 250 MHz clock
// Notes:   three copies share one bus: full, no realm pages, not capable
`timescale 1ns/1ps
module testbench;
	// ************
	// signals
	// ************
	logic        clk;
	logic        rst_b;
	logic        regReq;
	logic        regWrite;
	logic [1:0]  regSpace;
	logic [11:0] regOffset;
	logic [31:0] regWdata;
	logic [2:0]  ack;
	logic [31:0] rdata [3];
	logic [3:0]  ovEvent;
	logic [3:0]  ovEnable;
	logic        wrValid;
	logic        wrReady;
	logic [51:0] wrAddr;
	logic [1:0]  wrSpace;
	logic [3:0]  hwIrq;
	logic [31:0] lowM [4];
	logic [31:0] highM [4];
	int          failures;
	int          n_tests;
	int          cycles;
	int          hwCount;

	// ************
	// designs: full, then realm pages closed, then block absent
	// ************
	ofw_addr_regs dut_u
	(
		.clk(clk), .rst_b(rst_b), .regReq(regReq), .regWrite(regWrite),
		.regSpace(regSpace), .regOffset(regOffset), .regWdata(regWdata),
		.regAck(ack[0]), .regRdata(rdata[0]), .overflowEvent(ovEvent),
		.overflowIrqWriteEnable(ovEnable), .irqWriteValid(wrValid),
		.irqWriteReady(wrReady), .irqWriteAddr(wrAddr),
		.irqWriteSpace(wrSpace), .hardwiredIrq(hwIrq)
	);
	if (1)
	begin : noRealm
		ofw_addr_regs #(.REALM_SECURITY_EXTENSION(1'b0)) dut_u
		(
			.clk(clk), .rst_b(rst_b), .regReq(regReq), .regWrite(regWrite),
			.regSpace(regSpace), .regOffset(regOffset), .regWdata(regWdata),
			.regAck(ack[1]), .regRdata(rdata[1]), .overflowEvent(ovEvent),
			.overflowIrqWriteEnable(ovEnable), .irqWriteValid(),
			.irqWriteReady(wrReady), .irqWriteAddr(), .irqWriteSpace(),
			.hardwiredIrq()
		);
	end
	if (1)
	begin : noCap
		ofw_addr_regs #(.OVERFLOW_IRQ_WRITE_CAPABLE(1'b0)) dut_u
		(
			.clk(clk), .rst_b(rst_b), .regReq(regReq), .regWrite(regWrite),
			.regSpace(regSpace), .regOffset(regOffset), .regWdata(regWdata),
			.regAck(ack[2]), .regRdata(rdata[2]), .overflowEvent(ovEvent),
			.overflowIrqWriteEnable(ovEnable), .irqWriteValid(),
			.irqWriteReady(wrReady), .irqWriteAddr(), .irqWriteSpace(),
			.hardwiredIrq()
		);
	end

	// clock and hang guard; run needs about a hundred cycles
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures = failures + 1;
			end_of_test();
		end
	end
	// one-cycle pulses seen once at the falling edge
	always @(negedge clk)
		if (hwIrq !== 4'h0)
			hwCount++;

	// ************
	// tasks
	// ************
	task automatic chk(input logic [51:0] seen, input logic [51:0] exp,
		input string msg);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask

	// request held one edge; ack and read data stand for the next cycle
	// only, so they are taken before the following rising edge
	task automatic access(input logic wr, input logic [1:0] sp,
		input logic [11:0] off, input logic [31:0] wd);
		@(negedge clk);
		regReq = 1'b1;
		regWrite = wr;
		regSpace = sp;
		regOffset = off;
		regWdata = wd;
		@(negedge clk);
		regReq = 1'b0;
		chk(52'(ack), 52'h7, "ack");
	endtask

	task automatic wr(input logic [1:0] sp, input logic [11:0] off,
		input logic [31:0] wd);
		access(1'b1, sp, off, wd);
		if (off == ofw_pkg::OFF_ADDR_LOW)
			lowM[sp] = wd & 32'hFFFF_FFFC;
		if (off == ofw_pkg::OFF_ADDR_HIGH)
			highM[sp] = wd & 32'h000F_FFFF;
	endtask

	task automatic rd(input logic [1:0] sp, input logic [11:0] off,
		input logic [31:0] e);
		access(1'b0, sp, off, 32'h0000_0000);
		chk(52'(rdata[0]), 52'(e), "read full");
		chk(52'(rdata[1]), sp[1] ? 52'h0 : 52'(e), "read no realm");
		chk(52'(rdata[2]), 52'h0, "read absent");
	endtask

	// wait for a launch, hold it stalled a cycle, then accept
	task automatic take(input logic [1:0] sp);
		for (int i = 0; i < 8 && wrValid !== 1'b1; i++)
			@(negedge clk);
		chk(52'(wrValid), 52'h1, "valid");
		chk(52'(wrSpace), 52'(sp), "space");
		chk(wrAddr, {highM[sp][19:0], lowM[sp][31:2], 2'b00}, "addr");
		@(negedge clk);
		chk(52'(wrValid), 52'h1, "valid stands");
		wrReady = 1'b1;
		@(negedge clk);
		wrReady = 1'b0;
		chk(52'(wrValid), 52'h0, "valid drops");
	endtask

	task automatic pulse(input logic [3:0] ev, input logic [3:0] en);
		@(negedge clk);
		hwCount = 0;
		ovEnable = en;
		ovEvent = ev;
		@(negedge clk);
		ovEvent = 4'h0;
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ************
	// sequence
	// ************
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		regReq = 1'b0;
		regWrite = 1'b0;
		regSpace = 2'h0;
		regOffset = 12'h000;
		regWdata = 32'h0000_0000;
		ovEvent = 4'h0;
		ovEnable = 4'h0;
		wrReady = 1'b0;
		failures = 0;
		n_tests = 0;
		cycles = 0;
		hwCount = 0;
		for (int s = 0; s < 4; s++)
		begin
			lowM[s] = 32'h0000_0000;
			highM[s] = 32'h0000_0000;
		end
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			rd(2'(s), ofw_pkg::OFF_ADDR_LOW, 32'h0000_0000);
			rd(2'(s), ofw_pkg::OFF_ADDR_HIGH, 32'h0000_0000);
		end
		$display("test reset values done");
		// distinct per state, reserved bits and low bits of states 0 to 2 nonzero
		for (int s = 0; s < 4; s++)
		begin
			wr(2'(s), ofw_pkg::OFF_ADDR_LOW, {4{8'(s) ^ 8'hA7}});
			wr(2'(s), ofw_pkg::OFF_ADDR_HIGH, {4{8'(s) ^ 8'hF6}});
		end
		for (int s = 0; s < 4; s++)
		begin
			rd(2'(s), ofw_pkg::OFF_ADDR_LOW, lowM[s]);
			rd(2'(s), ofw_pkg::OFF_ADDR_HIGH, highM[s]);
		end
		$display("test per-state copies done");
		// unmapped offset: read zero, write lands nowhere
		wr(2'h0, 12'h08E8, 32'hFFFF_FFFF);
		rd(2'h0, 12'h08E8, 32'h0000_0000);
		rd(2'h0, ofw_pkg::OFF_ADDR_LOW, lowM[0]);
		$display("test unmapped offset done");
		pulse(4'b0100, 4'b1111);
		take(2'h2);
		chk(52'(hwCount), 52'h0, "no wired irq");
		pulse(4'b0010, 4'b0000);
		repeat (4) @(negedge clk);
		chk(52'(hwCount), 52'h1, "wired irq");
		chk(52'(wrValid), 52'h0, "no write");
		$display("test enable selects path done");
		wr(2'h3, ofw_pkg::OFF_ADDR_LOW, 32'h1234_5677);
		pulse(4'b1001, 4'b1111);
		take(2'h0);
		take(2'h3);
		chk(52'(hwCount), 52'h0, "no wired irq");
		$display("test two pending writes done");
		end_of_test();
	end
endmodule
